// [core/pcd_pkg.sv]
// constants and types shared by the command header decoder
package pcd_pkg;

  // header field positions
  localparam int HDR_CLASS_HI = 31;
  localparam int HDR_CLASS_LO = 29;
  localparam int HDR_PIPE_HI  = 28;
  localparam int HDR_PIPE_LO  = 27;
  localparam int HDR_OPC_HI   = 26;
  localparam int HDR_OPC_LO   = 24;
  localparam int HDR_SUB_HI   = 23;
  localparam int HDR_SUB_LO   = 16;
  localparam int HDR_SUBA_HI  = 23;
  localparam int HDR_SUBA_LO  = 21;
  localparam int HDR_SUBB_HI  = 20;
  localparam int HDR_SUBB_LO  = 16;

  // command class and pipeline type codes
  localparam logic [2:0] CLASS_PIPE  = 3'h3;
  localparam logic [2:0] CLASS_SIM   = 3'h7;
  localparam logic [1:0] PIPE_COMMON = 2'h0;
  localparam logic [1:0] PIPE_CODEC  = 2'h2;
  localparam logic [1:0] PIPE_3D     = 2'h3;

  // codec sub-opcode A groups
  localparam logic [2:0] SUBA_STATE  = 3'h0;
  localparam logic [2:0] SUBA_DEC    = 3'h1;
  localparam logic [2:0] SUBA_ENC    = 3'h2;

  // decoded command identity
  typedef enum logic [6:0] {
    CMD_NONE,
    CMD_HULL_STAGE_CONSTANTS, CMD_DOMAIN_STAGE_CONSTANTS, CMD_HULL_STAGE_STATE,
    CMD_TESSELLATOR_STATE, CMD_DOMAIN_STAGE_STATE, CMD_STREAM_OUTPUT_STATE,
    CMD_SETUP_BACKEND_STATE, CMD_PIXEL_STAGE_STATE, CMD_CLIP_VIEWPORT_POINTERS,
    CMD_CC_VIEWPORT_POINTERS, CMD_BLEND_POINTERS, CMD_DEPTH_STENCIL_POINTERS,
    CMD_SURF_VERTEX, CMD_SURF_HULL, CMD_SURF_DOMAIN, CMD_SURF_GEOMETRY, CMD_SURF_PIXEL,
    CMD_SAMP_VERTEX, CMD_SAMP_HULL, CMD_SAMP_DOMAIN, CMD_SAMP_GEOMETRY,
    CMD_UBUF_VERTEX, CMD_UBUF_HULL, CMD_UBUF_DOMAIN, CMD_UBUF_GEOMETRY,
    CMD_WINDOWER_COLORKEY, CMD_PIXEL_BLEND_STATE, CMD_WINDOWER_DEPTH_TEST,
    CMD_PIXEL_EXTRA_STATE, CMD_RASTER_SETUP, CMD_ATTRIBUTE_SWIZZLE,
    CMD_HIER_Z_OPERATION, CMD_INTERNAL_STATE,
    CMD_DRAW_RECT_BOUNDS, CMD_PALETTE_LOAD_FIRST, CMD_SAMPLER_COLORKEY,
    CMD_POLYGON_STIPPLE_OFFSET, CMD_POLYGON_STIPPLE_PATTERN, CMD_LINE_DASH_STATE,
    CMD_ANTIALIAS_LINE_PARAMS, CMD_GEOMETRY_VERTEXBUF_INDEX, CMD_PALETTE_LOAD_SECOND,
    CMD_SAMPLE_COUNT_STATE, CMD_STENCIL_SURFACE, CMD_HIER_DEPTH_SURFACE,
    CMD_DEPTH_CLEAR_PARAMS, CMD_MONO_FILTER_SIZE,
    CMD_PUSH_VERTEX, CMD_PUSH_HULL, CMD_PUSH_DOMAIN, CMD_PUSH_GEOMETRY, CMD_PUSH_PIXEL,
    CMD_STREAM_OUTPUT_DECLS, CMD_STREAM_OUTPUT_BUFFER, CMD_SAMPLE_POSITIONS,
    CMD_UNIFIED_BUFFER_CLEAR, CMD_PIPELINE_SYNC, CMD_DRAW_PRIMITIVE,
    CMD_DESCRIPTOR_PREFETCH, CMD_BASE_POINTER_SETUP, CMD_SYSTEM_ROUTINE_POINTER,
    CMD_SOFT_TESS_BASE, CMD_COMPUTE_SAVE_BASE,
    CMD_CODEC_MODE_SELECT, CMD_CODEC_SURFACE_SETUP, CMD_CODEC_BUFFER_POINTERS,
    CMD_CODEC_INDIRECT_BASE, CMD_CODEC_BITSTREAM_BASE, CMD_CODEC_UNNAMED,
    CMD_CODEC_STATE_POINTER, CMD_INVERSE_TRANSFORM_OBJECT,
    CMD_H264_IMAGE_SETUP, CMD_H264_QUANT_MATRIX, CMD_H264_DIRECT_MODE,
    CMD_H264_SLICE_SETUP, CMD_H264_REF_INDEX, CMD_H264_WEIGHT_OFFSET,
    CMD_H264_SLICE_DECODE_OBJECT, CMD_H264_FWD_QUANT_MATRIX,
    CMD_H264_HEADER_INSERT_OBJECT, CMD_H264_PACK_OBJECT,
    CMD_VC1_PICTURE_SETUP, CMD_VC1_PRED_PIPE_SETUP, CMD_VC1_DIRECT_MODE,
    CMD_VC1_SLICE_DECODE_OBJECT, CMD_MPEG2_PICTURE_SETUP, CMD_MPEG2_QUANT_MATRIX,
    CMD_MPEG2_SLICE_DECODE_OBJECT
  } pcd_cmd_t;

  // complete state of the decoder
  typedef struct packed {
    logic     valid;
    pcd_cmd_t id;
    logic     invalid;
    logic     intr;
    logic     drain;
  } pcd_state_t;

  localparam pcd_state_t PCD_STATE_RESET = '{1'b0, CMD_NONE, 1'b0, 1'b0, 1'b0};

endpackage

// [core/pcd_header_decoder.sv]
// command header decoder: pipeline-type, opcode and sub-opcode to command identity
//
// Overview of operation
// [RULE_01] Class 011 with pipeline type 3h is 3D space; opcode 26:24, sub 23:16.
// [RULE_02] Non-pipelined state commands request a render pipe drain before update.
// [RULE_03] Class 111 is simulator-only; hardware flags it invalid, never executes.
// [RULE_04] Codec parser: class 011, type 10, opcode picks standard, then sub A, B.
// [RULE_05] 3D opcode 0h, 19h-1Fh: hull/domain constants, hull, tess, domain, stream out, setup.
// [RULE_06] 3D opcode 0h: 20h pixel, 22h-25h viewport/blend/depth pointers; 21h reserved.
// [RULE_07] 3D opcode 0h, 26h-2Ah: surface-table pointers vertex..pixel in order.
// [RULE_08] 3D opcode 0h, 2Bh-2Eh: sampler pointers vertex..geometry; 2Fh reserved.
// [RULE_09] 3D opcode 0h, 30h-33h: unified-buffer allocation vertex..geometry.
// [RULE_10] 3D opcode 0h, 4Ch-53h windower/pixel/raster commands; rest reserved.
// [RULE_11] 3D opcode 1h, 00h-0Dh misc state; 03h and 05h reserved. The decoder also treats 01h and 09h as reserved.
// [RULE_12] 3D opcode 1h, 0Eh-11h: stencil, hier depth, depth clear, mono filter.
// [RULE_13] 3D opcode 1h, 12h-16h: push-constant allocation vertex..pixel.
// [RULE_14] 3D opcode 1h: 17h,18h,1Ch,1Dh named; 1Eh-FFh reserved.
// [RULE_15] 3D opcode 2h/00h pipeline sync, 3h/00h draw; others and 4h-7h reserved.
// [RULE_16] Common pipelined opcode 0h: 03h descriptor prefetch; 04h-FFh reserved.
// [RULE_17] Common non-pipelined opcode 1h: 01h-04h named; 00h, opcodes 2h-7h reserved.
// [RULE_18] Codec type 2h: opcode picks group, sub A 23:21, sub B 20:16.
// [RULE_19] Codec common state sub B 0h-6h named; 7h and 8h reserved.
// [RULE_20] Codec common object A 1h B 9h is inverse transform, interruptible.
// [RULE_21] H.264 state sub B 0h-5h named; 6h-1Fh reserved.
// [RULE_22] H.264 slice decode A 1h B 8h is not interruptible; rest reserved.
// [RULE_23] H.264 encode B 2h, 8h, 9h named; only pack object interruptible.
// [RULE_24] VC-1 state B 0h-2h named; decode object interruptible; encode reserved.
// [RULE_25] MPEG-2 state B 0h,1h named; decode object interruptible; encode reserved.
// [RULE_26] Software may use direct or indirect codec state; group picture apart.
// [RULE_27] Any unassigned field combination raises the reserved/invalid output.
// [RULE_28] A named command wins over an overlapping reserved range.
`timescale 1ns/10ps

module pcd_header_decoder
  import pcd_pkg::*;
(
  input  wire logic            mclk,             // parser clock, 25 MHz
  input  wire logic            arst_n,           // async reset, active low
  input  wire logic            hdrValid,         // header word present this cycle
  input  wire logic [31:0]     hdrWord,          // command header double-word
  input  wire logic            codecParser,      // high: codec parser map in use
  output logic                 cmdValid,         // one-cycle result strobe
  output pcd_pkg::pcd_cmd_t    cmdId,            // decoded command identity
  output logic                 cmdInvalid,       // reserved or invalid header
  output logic                 cmdInterruptible, // codec object may be interrupted
  output logic                 cmdDrain          // drain render pipe before update
);
  import pcd_pkg::*;

  pcd_state_t  stReg;
  pcd_state_t  stNext;
  logic [2:0]  cls;
  logic [1:0]  pipe;
  logic [2:0]  opc;
  logic [7:0]  sub;
  logic [7:0]  subAB;

  ////////////////////////////////////////////////////////////////////////////////
  // field split; the codec view reuses bits 23:16 as sub A and sub B
  assign cls   = hdrWord[HDR_CLASS_HI:HDR_CLASS_LO];
  assign pipe  = hdrWord[HDR_PIPE_HI:HDR_PIPE_LO];  // RULE_01
  assign opc   = hdrWord[HDR_OPC_HI:HDR_OPC_LO];
  assign sub   = hdrWord[HDR_SUB_HI:HDR_SUB_LO];
  assign subAB = {hdrWord[HDR_SUBA_HI:HDR_SUBA_LO], hdrWord[HDR_SUBB_HI:HDR_SUBB_LO]}; // RULE_18

  ////////////////////////////////////////////////////////////////////////////////
  // decode; every path starts from "nothing", so any gap in the map is reserved
  always_comb begin
    stNext       = PCD_STATE_RESET;
    stNext.valid = hdrValid;
    if (cls == CLASS_PIPE && !codecParser && pipe == PIPE_3D) begin  // RULE_01
      case (opc)
        3'h0: begin
          case (sub)
            8'h19: stNext.id = CMD_HULL_STAGE_CONSTANTS;    // RULE_05
            8'h1A: stNext.id = CMD_DOMAIN_STAGE_CONSTANTS;  // RULE_05
            8'h1B: stNext.id = CMD_HULL_STAGE_STATE;        // RULE_05
            8'h1C: stNext.id = CMD_TESSELLATOR_STATE;       // RULE_05
            8'h1D: stNext.id = CMD_DOMAIN_STAGE_STATE;      // RULE_05
            8'h1E: stNext.id = CMD_STREAM_OUTPUT_STATE;     // RULE_05
            8'h1F: stNext.id = CMD_SETUP_BACKEND_STATE;     // RULE_05
            8'h20: stNext.id = CMD_PIXEL_STAGE_STATE;       // RULE_06
            8'h22: stNext.id = CMD_CLIP_VIEWPORT_POINTERS;  // RULE_06
            8'h23: stNext.id = CMD_CC_VIEWPORT_POINTERS;    // RULE_06
            8'h24: stNext.id = CMD_BLEND_POINTERS;          // RULE_06
            8'h25: stNext.id = CMD_DEPTH_STENCIL_POINTERS;  // RULE_06
            8'h26: stNext.id = CMD_SURF_VERTEX;             // RULE_07
            8'h27: stNext.id = CMD_SURF_HULL;               // RULE_07
            8'h28: stNext.id = CMD_SURF_DOMAIN;             // RULE_07
            8'h29: stNext.id = CMD_SURF_GEOMETRY;           // RULE_07
            8'h2A: stNext.id = CMD_SURF_PIXEL;              // RULE_07
            8'h2B: stNext.id = CMD_SAMP_VERTEX;             // RULE_08
            8'h2C: stNext.id = CMD_SAMP_HULL;               // RULE_08
            8'h2D: stNext.id = CMD_SAMP_DOMAIN;             // RULE_08
            8'h2E: stNext.id = CMD_SAMP_GEOMETRY;           // RULE_08
            8'h30: stNext.id = CMD_UBUF_VERTEX;             // RULE_09
            8'h31: stNext.id = CMD_UBUF_HULL;               // RULE_09
            8'h32: stNext.id = CMD_UBUF_DOMAIN;             // RULE_09
            8'h33: stNext.id = CMD_UBUF_GEOMETRY;           // RULE_09
            8'h4C: stNext.id = CMD_WINDOWER_COLORKEY;       // RULE_10
            8'h4D: stNext.id = CMD_PIXEL_BLEND_STATE;       // RULE_10
            8'h4E: stNext.id = CMD_WINDOWER_DEPTH_TEST;     // RULE_10
            8'h4F: stNext.id = CMD_PIXEL_EXTRA_STATE;       // RULE_10
            8'h50: stNext.id = CMD_RASTER_SETUP;            // RULE_10
            8'h51: stNext.id = CMD_ATTRIBUTE_SWIZZLE;       // RULE_10
            8'h52: stNext.id = CMD_HIER_Z_OPERATION;        // RULE_10
            8'h53: stNext.id = CMD_INTERNAL_STATE;          // RULE_10
            default: stNext.id = CMD_NONE;                  // RULE_27
          endcase
        end
        3'h1: begin
          stNext.drain = 1'b1;                              // RULE_02
          case (sub)
            8'h00: stNext.id = CMD_DRAW_RECT_BOUNDS;        // RULE_11
            8'h02: stNext.id = CMD_PALETTE_LOAD_FIRST;      // RULE_11
            8'h04: stNext.id = CMD_SAMPLER_COLORKEY;        // RULE_11
            8'h06: stNext.id = CMD_POLYGON_STIPPLE_OFFSET;  // RULE_11
            8'h07: stNext.id = CMD_POLYGON_STIPPLE_PATTERN; // RULE_11
            8'h08: stNext.id = CMD_LINE_DASH_STATE;         // RULE_11
            8'h0A: stNext.id = CMD_ANTIALIAS_LINE_PARAMS;   // RULE_11
            8'h0B: stNext.id = CMD_GEOMETRY_VERTEXBUF_INDEX; // RULE_11
            8'h0C: stNext.id = CMD_PALETTE_LOAD_SECOND;     // RULE_11
            8'h0D: stNext.id = CMD_SAMPLE_COUNT_STATE;      // RULE_11
            8'h0E: stNext.id = CMD_STENCIL_SURFACE;         // RULE_12
            8'h0F: stNext.id = CMD_HIER_DEPTH_SURFACE;      // RULE_12
            8'h10: stNext.id = CMD_DEPTH_CLEAR_PARAMS;      // RULE_12
            8'h11: stNext.id = CMD_MONO_FILTER_SIZE;        // RULE_12
            8'h12: stNext.id = CMD_PUSH_VERTEX;             // RULE_13
            8'h13: stNext.id = CMD_PUSH_HULL;               // RULE_13
            8'h14: stNext.id = CMD_PUSH_DOMAIN;             // RULE_13
            8'h15: stNext.id = CMD_PUSH_GEOMETRY;           // RULE_13
            8'h16: stNext.id = CMD_PUSH_PIXEL;              // RULE_13
            8'h17: stNext.id = CMD_STREAM_OUTPUT_DECLS;     // RULE_14
            8'h18: stNext.id = CMD_STREAM_OUTPUT_BUFFER;    // RULE_14
            8'h1C: stNext.id = CMD_SAMPLE_POSITIONS;        // RULE_14
            8'h1D: stNext.id = CMD_UNIFIED_BUFFER_CLEAR;    // RULE_14
            default: stNext.id = CMD_NONE;                  // RULE_27
          endcase
        end
        3'h2: stNext.id = (sub == 8'h00) ? CMD_PIPELINE_SYNC : CMD_NONE;  // RULE_15
        3'h3: stNext.id = (sub == 8'h00) ? CMD_DRAW_PRIMITIVE : CMD_NONE; // RULE_15
        default: stNext.id = CMD_NONE;                      // RULE_15
      endcase
    end else if (cls == CLASS_PIPE && !codecParser && pipe == PIPE_COMMON) begin
      case (opc)
        3'h0: stNext.id = (sub == 8'h03) ? CMD_DESCRIPTOR_PREFETCH : CMD_NONE; // RULE_16
        3'h1: begin
          stNext.drain = 1'b1;                              // RULE_02
          // 04h is named even though it sits at the head of a reserved span
          case (sub)
            8'h01: stNext.id = CMD_BASE_POINTER_SETUP;      // RULE_17
            8'h02: stNext.id = CMD_SYSTEM_ROUTINE_POINTER;  // RULE_17
            8'h03: stNext.id = CMD_SOFT_TESS_BASE;          // RULE_17
            8'h04: stNext.id = CMD_COMPUTE_SAVE_BASE;       // RULE_28
            default: stNext.id = CMD_NONE;                  // RULE_17
          endcase
        end
        default: stNext.id = CMD_NONE;                      // RULE_17
      endcase
    end else if (cls == CLASS_PIPE && codecParser && pipe == PIPE_CODEC) begin // RULE_04
      // direct and indirect state arrive the same way here; no pointer chase
      case (opc)
        3'h0: begin
          case (subAB)
            {SUBA_STATE, 5'h00}: stNext.id = CMD_CODEC_MODE_SELECT;     // RULE_19
            {SUBA_STATE, 5'h01}: stNext.id = CMD_CODEC_SURFACE_SETUP;   // RULE_19
            {SUBA_STATE, 5'h02}: stNext.id = CMD_CODEC_BUFFER_POINTERS; // RULE_19
            {SUBA_STATE, 5'h03}: stNext.id = CMD_CODEC_INDIRECT_BASE;   // RULE_19
            {SUBA_STATE, 5'h04}: stNext.id = CMD_CODEC_BITSTREAM_BASE;  // RULE_28
            {SUBA_STATE, 5'h05}: stNext.id = CMD_CODEC_UNNAMED;         // RULE_19
            {SUBA_STATE, 5'h06}: stNext.id = CMD_CODEC_STATE_POINTER;   // RULE_19
            {SUBA_DEC, 5'h09}: begin
              stNext.id   = CMD_INVERSE_TRANSFORM_OBJECT;               // RULE_20
              stNext.intr = 1'b1;                                       // RULE_20
            end
            default: stNext.id = CMD_NONE;                              // RULE_19
          endcase
        end
        3'h1: begin
          case (subAB)
            {SUBA_STATE, 5'h00}: stNext.id = CMD_H264_IMAGE_SETUP;      // RULE_21
            {SUBA_STATE, 5'h01}: stNext.id = CMD_H264_QUANT_MATRIX;     // RULE_21
            {SUBA_STATE, 5'h02}: stNext.id = CMD_H264_DIRECT_MODE;      // RULE_21
            {SUBA_STATE, 5'h03}: stNext.id = CMD_H264_SLICE_SETUP;      // RULE_21
            {SUBA_STATE, 5'h04}: stNext.id = CMD_H264_REF_INDEX;        // RULE_21
            {SUBA_STATE, 5'h05}: stNext.id = CMD_H264_WEIGHT_OFFSET;    // RULE_21
            {SUBA_DEC, 5'h08}:   stNext.id = CMD_H264_SLICE_DECODE_OBJECT; // RULE_22
            {SUBA_ENC, 5'h02}:   stNext.id = CMD_H264_FWD_QUANT_MATRIX; // RULE_23
            {SUBA_ENC, 5'h08}:   stNext.id = CMD_H264_HEADER_INSERT_OBJECT; // RULE_23
            {SUBA_ENC, 5'h09}: begin
              stNext.id   = CMD_H264_PACK_OBJECT;                       // RULE_23
              stNext.intr = 1'b1;                                       // RULE_23
            end
            default: stNext.id = CMD_NONE;                              // RULE_21
          endcase
        end
        3'h2: begin
          case (subAB)
            {SUBA_STATE, 5'h00}: stNext.id = CMD_VC1_PICTURE_SETUP;     // RULE_24
            {SUBA_STATE, 5'h01}: stNext.id = CMD_VC1_PRED_PIPE_SETUP;   // RULE_24
            {SUBA_STATE, 5'h02}: stNext.id = CMD_VC1_DIRECT_MODE;       // RULE_28
            {SUBA_DEC, 5'h08}: begin
              stNext.id   = CMD_VC1_SLICE_DECODE_OBJECT;                // RULE_24
              stNext.intr = 1'b1;                                       // RULE_24
            end
            default: stNext.id = CMD_NONE;                              // RULE_24
          endcase
        end
        3'h3: begin
          case (subAB)
            {SUBA_STATE, 5'h00}: stNext.id = CMD_MPEG2_PICTURE_SETUP;   // RULE_25
            {SUBA_STATE, 5'h01}: stNext.id = CMD_MPEG2_QUANT_MATRIX;    // RULE_25
            {SUBA_DEC, 5'h08}: begin
              stNext.id   = CMD_MPEG2_SLICE_DECODE_OBJECT;              // RULE_25
              stNext.intr = 1'b1;                                       // RULE_25
            end
            default: stNext.id = CMD_NONE;                              // RULE_25
          endcase
        end
        default: stNext.id = CMD_NONE;                                  // RULE_18
      endcase
    end
    // simulator class 111 and all other classes fall through as unassigned
    stNext.invalid = hdrValid && (stNext.id == CMD_NONE);               // RULE_27 RULE_03
    stNext.drain   = stNext.drain && hdrValid && !stNext.invalid;       // RULE_02
    if (!hdrValid) begin
      stNext.id   = CMD_NONE;
      stNext.intr = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; result appears one edge after the header is offered
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stReg <= PCD_STATE_RESET;
    end else begin
      stReg <= stNext;
    end
  end

  assign cmdValid         = stReg.valid;
  assign cmdId            = stReg.id;
  assign cmdInvalid       = stReg.invalid;
  assign cmdInterruptible = stReg.intr;
  assign cmdDrain         = stReg.drain;

  ////////////////////////////////////////////////////////////////////////////////
  // checks on the decoded result
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence hdr3d(logic [2:0] o, logic [7:0] s);
    hdrValid && !codecParser && cls == CLASS_PIPE && pipe == PIPE_3D && opc == o && sub == s;
  endsequence

  sequence hdrCodec(logic [2:0] o, logic [7:0] ab);
    hdrValid && codecParser && cls == CLASS_PIPE && pipe == PIPE_CODEC && opc == o && subAB == ab;
  endsequence

  sequence hdrCommon(logic [2:0] o, logic [7:0] s);
    hdrValid && !codecParser && cls == CLASS_PIPE && pipe == PIPE_COMMON && opc == o && sub == s;
  endsequence

  sim_invalid_a: assert property (hdrValid && cls == CLASS_SIM // RULE_03
      |=> cmdInvalid && !cmdDrain)
    else $error("simulator class header not flagged invalid");

  hull_constants_a: assert property (hdr3d(3'h0, 8'h19) // RULE_05
      |=> cmdId == CMD_HULL_STAGE_CONSTANTS)
    else $error("hull constants misdecoded");

  gap_21_a: assert property (hdr3d(3'h0, 8'h21) // RULE_06
      |=> cmdInvalid && cmdValid)
    else $error("sub-opcode 21h not reserved");

  surf_pixel_a: assert property (hdr3d(3'h0, 8'h2A) // RULE_07
      |=> cmdId == CMD_SURF_PIXEL && !cmdInvalid)
    else $error("pixel surface table pointer misdecoded");

  samp_gap_a: assert property (hdr3d(3'h0, 8'h2F) // RULE_08
      |=> cmdInvalid)
    else $error("sub-opcode 2Fh not reserved");

  ubuf_geom_a: assert property (hdr3d(3'h0, 8'h33) // RULE_09
      |=> cmdId == CMD_UBUF_GEOMETRY)
    else $error("geometry buffer allocation misdecoded");

  colorkey_a: assert property (hdr3d(3'h0, 8'h4C) // RULE_10
      |=> cmdId == CMD_WINDOWER_COLORKEY && !cmdDrain)
    else $error("windower color key misdecoded");

  np_gap_a: assert property (hdr3d(3'h1, 8'h03) // RULE_11
      |=> cmdInvalid && !cmdDrain)
    else $error("non-pipelined 03h not reserved");

  np_drain_a: assert property (hdr3d(3'h1, 8'h0D) // RULE_02
      |=> cmdDrain ##1 !cmdDrain || $past(hdrValid))
    else $error("non-pipelined state did not request drain");

  push_pixel_a: assert property (hdr3d(3'h1, 8'h16) // RULE_13
      |=> cmdId == CMD_PUSH_PIXEL && cmdDrain)
    else $error("pixel push-constant allocation misdecoded");

  draw_prim_a: assert property (hdr3d(3'h3, 8'h00) // RULE_15
      |=> cmdId == CMD_DRAW_PRIMITIVE && !cmdDrain)
    else $error("draw primitive misdecoded");

  prefetch_a: assert property (hdrCommon(3'h0, 8'h03) // RULE_16
      |=> cmdId == CMD_DESCRIPTOR_PREFETCH && !cmdDrain)
    else $error("descriptor prefetch misdecoded");

  compute_save_a: assert property (hdrCommon(3'h1, 8'h04) // RULE_28
      |=> cmdId == CMD_COMPUTE_SAVE_BASE && !cmdInvalid)
    else $error("named command lost to reserved range");

  mode_select_a: assert property (hdrCodec(3'h0, {SUBA_STATE, 5'h00}) // RULE_19
      |=> cmdId == CMD_CODEC_MODE_SELECT && !cmdInterruptible)
    else $error("codec mode select misdecoded");

  itrans_intr_a: assert property (hdrCodec(3'h0, {SUBA_DEC, 5'h09}) // RULE_20
      |=> cmdId == CMD_INVERSE_TRANSFORM_OBJECT && cmdInterruptible)
    else $error("inverse transform object not interruptible");

  h264_slice_a: assert property (hdrCodec(3'h1, {SUBA_DEC, 5'h08}) // RULE_22
      |=> cmdId == CMD_H264_SLICE_DECODE_OBJECT && !cmdInterruptible)
    else $error("slice decode object marked interruptible");

  pack_intr_a: assert property (hdrCodec(3'h1, {SUBA_ENC, 5'h09}) // RULE_23
      |=> cmdInterruptible)
    else $error("pack object not interruptible");

  vc1_intr_a: assert property (hdrCodec(3'h2, {SUBA_DEC, 5'h08}) // RULE_24
      |=> cmdId == CMD_VC1_SLICE_DECODE_OBJECT && cmdInterruptible)
    else $error("vc1 decode object not interruptible");

  mpeg2_enc_a: assert property (hdrCodec(3'h3, {SUBA_ENC, 5'h05}) // RULE_25
      |=> cmdInvalid && !cmdInterruptible)
    else $error("mpeg2 encode group not reserved");

  strobe_pair_a: assert property (cmdValid == $past(hdrValid) // RULE_27
      && (!cmdInvalid || cmdValid))
    else $error("result strobe does not follow header strobe");

endmodule // pcd_header_decoder

// [tb/pcd_stream_model.sv]
// partner model: command streamer offering header words to the decoder
`timescale 1ns/10ps
module pcd_stream_model (
  input  wire logic        mclk,        // parser clock
  output logic             hdrValid,    // header offered this cycle
  output logic [31:0]      hdrWord,     // header double-word
  output logic             codecParser  // codec map select
);
  // nothing offered at time zero
  initial begin
    hdrValid = 1'b0;
    hdrWord = 32'h0000_0000;
    codecParser = 1'b0;
  end
  // one header a call, launched just after an edge so back to back is one a cycle
  task automatic send(input logic [31:0] w, input logic c);
    @(posedge mclk);
    hdrValid <= 1'b1;
    hdrWord <= w;
    codecParser <= c;
  endtask
  // released word turns to its inverse so a stale value never passes as live
  task automatic rest();
    @(posedge mclk);
    hdrValid <= 1'b0;
    hdrWord <= ~hdrWord;
  endtask
endmodule // pcd_stream_model

// [tb/testbench.sv]
// self-checking bench for the command header decoder
`timescale 1ns/10ps
module testbench;
  import pcd_pkg::*;
  logic        mclk, arst_n, hdrValid, codecParser, cmdValid, cmdInvalid;
  logic        cmdInterruptible, cmdDrain, dueV, c;
  logic [31:0] hdrWord, w;
  logic [1:0]  expFl, dueFl;
  pcd_cmd_t    cmdId, expId, dueId;
  int          errors, checkCount;

  pcd_stream_model i_src (.mclk(mclk), .hdrValid(hdrValid), .hdrWord(hdrWord),
                          .codecParser(codecParser));
  pcd_header_decoder i_dut (.mclk(mclk), .arst_n(arst_n), .hdrValid(hdrValid),
    .hdrWord(hdrWord), .codecParser(codecParser), .cmdValid(cmdValid), .cmdId(cmdId),
    .cmdInvalid(cmdInvalid), .cmdInterruptible(cmdInterruptible), .cmdDrain(cmdDrain));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic completeRun();
    if (errors == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // header word built field by field from the documented layout
  function automatic logic [31:0] hd(input logic [1:0] p, input logic [2:0] o,
                                     input logic [7:0] s);
    return {CLASS_PIPE, p, o, s, 16'h0000};
  endfunction
  task automatic put(input logic [31:0] hw, input logic cm, input pcd_cmd_t id,
                     input logic [1:0] fl);
    i_src.send(hw, cm);
    expId <= id;
    expFl <= fl;
  endtask
  // render map; opcode 1h named commands are non-pipelined and must drain
  task automatic r3(input logic [1:0] p, input logic [2:0] o, input logic [7:0] s,
                    input pcd_cmd_t id);
    put(hd(p, o, s), 1'b0, id, {1'b0, o == 3'h1 && id != CMD_NONE});
  endtask
  task automatic rc(input logic [2:0] o, input logic [2:0] a, input logic [4:0] b,
                    input pcd_cmd_t id, input logic it);
    put(hd(PIPE_CODEC, o, {a, b}), 1'b1, id, {it, 1'b0});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // expectation follows the taken header by exactly one edge
  always @(posedge mclk) begin
    dueV <= hdrValid;
    dueId <= expId;
    dueFl <= expFl;
  end
  always @(negedge mclk) if (arst_n) begin
    chk("valid", 8'(cmdValid), 8'(dueV));
    chk("id", 8'(cmdId), 8'(dueV ? dueId : CMD_NONE));
    chk("invalid", 8'(cmdInvalid), 8'(dueV && dueId == CMD_NONE));
    chk("intr", 8'(cmdInterruptible), 8'(dueV & dueFl[1]));
    chk("drain", 8'(cmdDrain), 8'(dueV & dueFl[0]));
  end
  // hang guard: whole sequence needs well under a thousand cycles
  initial begin
    #(40 * 4000);
    errors++;
    completeRun();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(2782));
    errors = 0;
    checkCount = 0;
    arst_n = 1'b0;
    expId = CMD_NONE;
    expFl = 2'b00;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
      r3(PIPE_3D, 0, 8'h19 + 8'(i), pcd_cmd_t'(CMD_HULL_STAGE_CONSTANTS + i));
    for (int i = 0; i < 6; i++)
      r3(PIPE_3D, 0, 8'h20 + 8'(i),
         i == 1 ? CMD_NONE : pcd_cmd_t'(CMD_PIXEL_STAGE_STATE + i - (i > 1)));
    for (int i = 0; i < 14; i++)
      r3(PIPE_3D, 0, 8'h26 + 8'(i),
         i == 9 ? CMD_NONE : pcd_cmd_t'(CMD_SURF_VERTEX + i - (i > 9)));
    // 48h-4Bh below the named span, 54h and 55h above it
    for (int i = 0; i < 14; i++)
      r3(PIPE_3D, 0, 8'h48 + 8'(i),
         (i < 4 || i > 11) ? CMD_NONE : pcd_cmd_t'(CMD_WINDOWER_COLORKEY + i - 4));
    r3(PIPE_3D, 0, 8'hFF, CMD_NONE);
    r3(PIPE_3D, 1, 8'h00, CMD_DRAW_RECT_BOUNDS);
    r3(PIPE_3D, 1, 8'h03, CMD_NONE);
    r3(PIPE_3D, 1, 8'h0D, CMD_SAMPLE_COUNT_STATE);
    for (int i = 0; i < 9; i++)
      r3(PIPE_3D, 1, 8'h0E + 8'(i), pcd_cmd_t'(CMD_STENCIL_SURFACE + i));
    r3(PIPE_3D, 1, 8'h1D, CMD_UNIFIED_BUFFER_CLEAR);
    r3(PIPE_3D, 2, 8'h00, CMD_PIPELINE_SYNC);
    r3(PIPE_3D, 2, 8'h01, CMD_NONE);
    r3(PIPE_3D, 3, 8'h00, CMD_DRAW_PRIMITIVE);
    r3(PIPE_COMMON, 0, 8'h03, CMD_DESCRIPTOR_PREFETCH);
    r3(PIPE_COMMON, 0, 8'h04, CMD_NONE);
    r3(PIPE_COMMON, 1, 8'h00, CMD_NONE);
    r3(PIPE_COMMON, 1, 8'h01, CMD_BASE_POINTER_SETUP);
    r3(PIPE_COMMON, 1, 8'h04, CMD_COMPUTE_SAVE_BASE);
    r3(PIPE_COMMON, 2, 8'h01, CMD_NONE);
    put(hd(PIPE_3D, 0, 8'h19), 1'b1, CMD_NONE, 2'b00);
    put(hd(PIPE_CODEC, 0, 8'h00), 1'b0, CMD_NONE, 2'b00);
    rc(0, 0, 0, CMD_CODEC_MODE_SELECT, 0);
    rc(0, 0, 6, CMD_CODEC_STATE_POINTER, 0);
    rc(0, 0, 7, CMD_NONE, 0);
    rc(0, 0, 4, CMD_CODEC_BITSTREAM_BASE, 0);
    rc(0, 1, 9, CMD_INVERSE_TRANSFORM_OBJECT, 1);
    rc(1, 0, 5, CMD_H264_WEIGHT_OFFSET, 0);
    rc(1, 0, 6, CMD_NONE, 0);
    rc(1, 1, 8, CMD_H264_SLICE_DECODE_OBJECT, 0);
    rc(1, 1, 9, CMD_NONE, 0);
    rc(1, 2, 2, CMD_H264_FWD_QUANT_MATRIX, 0);
    rc(1, 2, 8, CMD_H264_HEADER_INSERT_OBJECT, 0);
    rc(1, 2, 9, CMD_H264_PACK_OBJECT, 1);
    rc(2, 0, 2, CMD_VC1_DIRECT_MODE, 0);
    rc(2, 1, 8, CMD_VC1_SLICE_DECODE_OBJECT, 1);
    rc(2, 2, 0, CMD_NONE, 0);
    rc(3, 0, 1, CMD_MPEG2_QUANT_MATRIX, 0);
    rc(3, 1, 8, CMD_MPEG2_SLICE_DECODE_OBJECT, 1);
    rc(3, 2, 5, CMD_NONE, 0);
    // random reserved headers, with idle gaps mixed into back-to-back runs
    repeat (200) begin
      w = $urandom;
      c = w[3];
      case (w[5:4])
        2'd0: w[31:29] = CLASS_SIM;
        2'd1: w = hd(PIPE_3D, 3'h4 | w[2:0], w[15:8]);
        2'd2: w = hd(PIPE_3D, 3'h1, 8'h1E + 8'(w[15:8] % 8'hE2));
        default: begin
          w[31:24] = {CLASS_PIPE, PIPE_CODEC, 1'b1, w[1:0]};
          c = 1'b1;
        end
      endcase
      put(w, c, CMD_NONE, 2'b00);
      if (w[6]) i_src.rest();
    end
    i_src.rest();
    repeat (3) @(posedge mclk);
    completeRun();
  end
endmodule // testbench
